/* rtl/parallel_calendar_clock_regs.v */
// Parallel bus calendar clock: pin synchroniser, registers, timebase and timing pulse
//
// Function
// - A register access counts only while the low select is low and the high select is high.
// - On the rising write strobe the data byte is stored into the selected register.
// - During a read strobe the selected register is driven onto the byte bus.
// - The timing pulse output only pulls low as an open drain and floats otherwise.
// - Seconds sit at index 0 through year at 6, mode and control at 7, tens in the upper nibble.
// - In twelve hour mode the afternoon flag reads 0 for morning, 1 for afternoon, and is writable.
// - In twenty four hour mode the afternoon flag is held at zero.
// - The hour format flag selects 24 hour counting at 0 and 12 hour at 1, readable and writable.
// - Time and calendar counters advance from the 32.768 kHz crystal timebase.
// - Leap control 10 disables leap years so February 28 rolls to March 1.
// - Reads during an update never disturb the counters though the data may be inconsistent.
// - The oscillation flag clears at power up and stays clear until a clock reset while running.
`timescale 1ns/1ps
module parallel_calendar_clock_regs (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Host bus pins
  input  wire       select_low_active_n_i,
  input  wire       select_high_active_i,
  input  wire       write_strobe_n_i,
  input  wire       read_strobe_n_i,
  input  wire [2:0] register_select_lines_i,
  input  wire [7:0] byte_bus_i,
  output reg  [7:0] byte_bus_o,
  output reg        byte_bus_oe_o,
  // Open drain timing pulse
  output reg        timing_pulse_out_o,
  output reg        timing_pulse_out_oe_o,
  // Crystal pins
  input  wire       crystal_in_i,
  output reg        crystal_out_o
);
`include "calendar_clock_defs.vh"

  // Pin synchroniser stages and filtered pin state
  reg  [15:0] pin_s1;
  reg  [15:0] pin_s2;
  reg  [15:0] pin_s3;
  reg  [15:0] pin_f;
  wire [15:0] pin_raw;
  // Bus capture state
  reg         wr_q;
  reg         wr_armed;
  reg  [2:0]  wr_addr;
  reg  [7:0]  wr_data;
  reg         xtal_q;
  // Time and calendar registers
  reg  [7:0]  seconds_bcd;
  reg  [7:0]  minutes_bcd;
  reg  [7:0]  hours_bcd_with_format;
  reg  [7:0]  leap_and_weekday;
  reg  [7:0]  day_of_month_bcd;
  reg  [7:0]  month_bcd;
  reg  [7:0]  year_bcd;
  // Mode and control state
  reg  [3:0]  mode;
  reg         clk_stop;
  reg         tp_disable;
  reg         int_stop;
  reg         oscillation_flag;
  reg         int_low;
  reg         tp_flag;
  reg  [14:0] prescaler;
  reg  [11:0] osc_watch;
  // Combinational helpers
  reg         tp_low;
  reg         int_event;
  reg  [7:0]  adv_sec_in;
  wire [7:0]  adv_sec;
  wire [7:0]  adv_min;
  wire [7:0]  adv_hour;
  wire [7:0]  adv_leap;
  wire [7:0]  adv_day;
  wire [7:0]  adv_mon;
  wire [7:0]  adv_year;

  assign pin_raw = {crystal_in_i, select_low_active_n_i, select_high_active_i,
                    write_strobe_n_i, read_strobe_n_i, register_select_lines_i, byte_bus_i};

  // Filtered pin fields
  wire       xtal_f   = pin_f[15];
  wire       selected = ~pin_f[14] & pin_f[13];
  wire       wr_f     = pin_f[12];
  wire       rd_f     = pin_f[11];
  wire [2:0] addr_f   = pin_f[10:8];
  wire [7:0] data_f   = pin_f[7:0];

  // Write events: rising strobe after a low phase seen while selected
  wire do_wr      = wr_f & ~wr_q & wr_armed;
  wire wr_ctrl    = do_wr & (wr_addr == `ADDR_MODE_CTRL);
  wire bank0      = wr_ctrl & ~wr_data[`CTRL_BANK_BIT];
  wire bank1      = wr_ctrl & wr_data[`CTRL_BANK_BIT];
  wire clk_adjust = bank0 & wr_data[`CTRL_ADJ_BIT];
  wire clk_reset  = bank0 & wr_data[`CTRL_RST_BIT];
  wire int_reset  = bank1 & wr_data[`CTRL_RST_BIT];

  // Timebase events
  wire xtal_edge   = xtal_f & ~xtal_q;
  wire xtal_count  = xtal_edge & ~clk_stop;
  wire osc_running = (osc_watch < `OSC_TIMEOUT_CYC);
  wire tick        = xtal_count & (prescaler == `PRESC_FULL);
  wire adj_carry   = clk_adjust & (seconds_bcd >= `ADJ_THRESHOLD);
  wire advance     = tick | adj_carry;
  // Busy over the last 32 crystal periods before each second rolls
  wire busy        = &prescaler[14:5];

  // Read multiplexer over the eight registers
  function [7:0] read_reg;
    input [2:0] a;
    begin
      case (a)
        `ADDR_SECONDS:   read_reg = seconds_bcd;
        `ADDR_MINUTES:   read_reg = minutes_bcd;
        `ADDR_HOURS:     read_reg = hours_bcd_with_format;
        `ADDR_LEAP_WDAY: read_reg = leap_and_weekday;
        `ADDR_DAY:       read_reg = day_of_month_bcd;
        `ADDR_MONTH:     read_reg = month_bcd;
        `ADDR_YEAR:      read_reg = year_bcd;
        default:         read_reg = {mode, 1'b0, tp_flag, oscillation_flag, busy};
      endcase
    end
  endfunction

  // Three stage synchroniser; a bit changes once stages two and three agree
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= 16'h7800;
      pin_s2 <= 16'h7800;
      pin_s3 <= 16'h7800;
      pin_f  <= 16'h7800;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  // Data and address are held from the low phase, since hold time at the edge is zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q     <= 1'b1;
      wr_armed <= 1'b0;
      wr_addr  <= 3'h0;
      wr_data  <= 8'h00;
      xtal_q   <= 1'b0;
    end else begin
      wr_q   <= wr_f;
      xtal_q <= xtal_f;
      if (!wr_f && selected) begin
        wr_armed <= 1'b1;
        wr_addr  <= addr_f;
        wr_data  <= data_f;
      end else if (wr_f) begin
        wr_armed <= 1'b0;
      end
    end
  end

  // Adjust below 30 s only zeroes seconds; at or above it carries into minutes
  always @* begin
    adv_sec_in = adj_carry ? 8'h59 : seconds_bcd;
  end

  calendar_advance u_advance (
    .sec_i       (adv_sec_in),
    .min_i       (minutes_bcd),
    .hour_i      (hours_bcd_with_format),
    .leap_wday_i (leap_and_weekday),
    .day_i       (day_of_month_bcd),
    .month_i     (month_bcd),
    .year_i      (year_bcd),
    .sec_o       (adv_sec),
    .min_o       (adv_min),
    .hour_o      (adv_hour),
    .leap_wday_o (adv_leap),
    .day_o       (adv_day),
    .month_o     (adv_mon),
    .year_o      (adv_year)
  );

  // Counter registers; a host write to a register wins over the advance
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seconds_bcd           <= `RST_SECONDS;
      minutes_bcd           <= `RST_MINUTES;
      hours_bcd_with_format <= `RST_HOURS;
      leap_and_weekday      <= `RST_LEAP_WDAY;
      day_of_month_bcd      <= `RST_DAY;
      month_bcd             <= `RST_MONTH;
      year_bcd              <= `RST_YEAR;
    end else begin
      if (do_wr && wr_addr == `ADDR_SECONDS) begin
        seconds_bcd <= wr_data;
      end else if (advance) begin
        seconds_bcd <= adv_sec;
      end else if (clk_adjust) begin
        seconds_bcd <= 8'h00;
      end
      if (do_wr && wr_addr == `ADDR_MINUTES) begin
        minutes_bcd <= wr_data;
      end else if (advance) begin
        minutes_bcd <= adv_min;
      end
      if (do_wr && wr_addr == `ADDR_HOURS) begin
        // Afternoon flag kept only in 12 hour format
        hours_bcd_with_format <= {wr_data[`HOUR_FMT_BIT],
                                  wr_data[`HOUR_FMT_BIT] & wr_data[`HOUR_PM_BIT],
                                  wr_data[5:0]};
      end else if (advance) begin
        hours_bcd_with_format <= adv_hour;
      end
      if (do_wr && wr_addr == `ADDR_LEAP_WDAY) begin
        // Leap counter bits change only when the write enable bit is set
        leap_and_weekday <= {wr_data[7:6],
                             wr_data[`LEAP_WREN_BIT] ? wr_data[5:4] : leap_and_weekday[5:4],
                             wr_data[3:0]};
      end else if (advance) begin
        leap_and_weekday <= adv_leap;
      end
      if (do_wr && wr_addr == `ADDR_DAY) begin
        day_of_month_bcd <= wr_data;
      end else if (advance) begin
        day_of_month_bcd <= adv_day;
      end
      if (do_wr && wr_addr == `ADDR_MONTH) begin
        month_bcd <= wr_data;
      end else if (advance) begin
        month_bcd <= adv_mon;
      end
      if (do_wr && wr_addr == `ADDR_YEAR) begin
        year_bcd <= wr_data;
      end else if (advance) begin
        year_bcd <= adv_year;
      end
    end
  end

  // Crystal divider and loss watchdog
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescaler <= 15'h0000;
      osc_watch <= 12'hfff;
    end else begin
      if (clk_reset || clk_adjust) begin
        prescaler <= 15'h0000;
      end else if (xtal_count) begin
        prescaler <= prescaler + 15'h0001;
      end
      if (xtal_edge) begin
        osc_watch <= 12'h000;
      end else if (osc_running) begin
        osc_watch <= osc_watch + 12'h001;
      end
    end
  end

  // Mode and control bits; a lost crystal beats a clock reset in the same cycle
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode             <= `RST_MODE;
      clk_stop         <= 1'b0;
      tp_disable       <= 1'b0;
      int_stop         <= 1'b0;
      oscillation_flag <= 1'b0;
      int_low          <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        mode <= wr_data[7:4];
      end
      if (bank0) begin
        clk_stop <= wr_data[`CTRL_STOP_BIT];
      end
      if (bank1) begin
        tp_disable <= wr_data[`CTRL_ADJ_BIT];
        int_stop   <= wr_data[`CTRL_STOP_BIT];
      end
      if (!osc_running) begin
        oscillation_flag <= 1'b0;
      end else if (clk_reset) begin
        oscillation_flag <= 1'b1;
      end
      // Interval event sets the level; set wins over INT reset
      if (int_event && !int_stop) begin
        int_low <= 1'b1;
      end else if (int_reset) begin
        int_low <= 1'b0;
      end
    end
  end

  // Interval event and pulse level chosen by the mode nibble
  always @* begin
    int_event = 1'b0;
    tp_low    = 1'b0;
    case (mode)
      4'h0:    tp_low = ~prescaler[3];
      4'h1:    tp_low = ~prescaler[4];
      4'h2:    tp_low = ~prescaler[6];
      4'h3:    tp_low = ~prescaler[8];
      4'h4:    int_event = xtal_count & (&prescaler[3:0]);
      4'h5:    int_event = xtal_count & (&prescaler[4:0]);
      4'h6:    int_event = xtal_count & (&prescaler[6:0]);
      4'h7:    int_event = xtal_count & (&prescaler[8:0]);
      4'h8:    int_event = tick;
      4'h9:    int_event = tick & (seconds_bcd[3:0] == 4'h9);
      4'ha:    int_event = tick & (seconds_bcd == 8'h59);
      4'hb:    tp_low = busy;
      default: tp_low = 1'b0;
    endcase
    if (mode >= 4'h4 && mode <= 4'ha) begin
      tp_low = int_low;
    end
  end

  // Pins: the pulse pin only ever pulls low; reads never touch the counters
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tp_flag               <= 1'b0;
      timing_pulse_out_o    <= 1'b0;
      timing_pulse_out_oe_o <= 1'b0;
      byte_bus_o            <= 8'h00;
      byte_bus_oe_o         <= 1'b0;
      crystal_out_o         <= 1'b1;
    end else begin
      tp_flag               <= tp_low;
      timing_pulse_out_o    <= 1'b0;
      timing_pulse_out_oe_o <= tp_low & ~tp_disable;
      byte_bus_oe_o         <= selected & ~rd_f;
      byte_bus_o            <= (selected & ~rd_f) ? read_reg(addr_f) : 8'h00;
      crystal_out_o         <= ~xtal_f;
    end
  end

endmodule // parallel_calendar_clock_regs

/* pkg/calendar_clock_defs.vh */
// Constants shared by the calendar clock register block
`ifndef CALENDAR_CLOCK_DEFS_VH
`define CALENDAR_CLOCK_DEFS_VH

// Register indices on the three select lines
`define ADDR_SECONDS     3'h0
`define ADDR_MINUTES     3'h1
`define ADDR_HOURS       3'h2
`define ADDR_LEAP_WDAY   3'h3
`define ADDR_DAY         3'h4
`define ADDR_MONTH       3'h5
`define ADDR_YEAR        3'h6
`define ADDR_MODE_CTRL   3'h7

// Field positions
`define HOUR_FMT_BIT     7
`define HOUR_PM_BIT      6
`define LEAP_OFF_BIT     7
`define LEAP_WREN_BIT    6
`define CTRL_BANK_BIT    3
`define CTRL_ADJ_BIT     2
`define CTRL_RST_BIT     1
`define CTRL_STOP_BIT    0

// Reset values
`define RST_SECONDS      8'h00
`define RST_MINUTES      8'h00
`define RST_HOURS        8'h00
`define RST_LEAP_WDAY    8'h00
`define RST_DAY          8'h01
`define RST_MONTH        8'h01
`define RST_YEAR         8'h00
`define RST_MODE         4'h0

// Timing: system clock rate and crystal loss timeout
`define CLK_HZ           20000000
`define OSC_TIMEOUT_US   100
`define OSC_TIMEOUT_CYC  ((`OSC_TIMEOUT_US * `CLK_HZ) / 1000000)

// Crystal divider: full count for one second, adjust carry threshold for seconds
`define PRESC_FULL       15'h7fff
`define ADJ_THRESHOLD    8'h30

`endif

/* rtl/calendar_advance.v */
// Combinational one-second advance of the BCD time and calendar counters
`timescale 1ns/1ps
module calendar_advance (
  // Present counter values
  input  wire [7:0] sec_i,
  input  wire [7:0] min_i,
  input  wire [7:0] hour_i,
  input  wire [7:0] leap_wday_i,
  input  wire [7:0] day_i,
  input  wire [7:0] month_i,
  input  wire [7:0] year_i,
  // Values one second later
  output reg  [7:0] sec_o,
  output reg  [7:0] min_o,
  output reg  [7:0] hour_o,
  output reg  [7:0] leap_wday_o,
  output reg  [7:0] day_o,
  output reg  [7:0] month_o,
  output reg  [7:0] year_o
);
`include "calendar_clock_defs.vh"

  // BCD increment of a two digit byte
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
    end
  endfunction

  reg       c_min;
  reg       c_hour;
  reg       c_day;
  reg       c_mon;
  reg       c_year;
  reg [7:0] last_day;
  reg       leap_now;

  // Ripple of carries from seconds up to year
  always @* begin
    c_min = (sec_i == 8'h59);
    sec_o = c_min ? 8'h00 : bcd_inc(sec_i);
    c_hour = 1'b0;
    min_o = min_i;
    if (c_min) begin
      c_hour = (min_i == 8'h59);
      min_o  = c_hour ? 8'h00 : bcd_inc(min_i);
    end
    c_day  = 1'b0;
    hour_o = hour_i;
    if (c_hour) begin
      if (!hour_i[`HOUR_FMT_BIT]) begin
        // 24 hour count, afternoon flag held low
        c_day  = (hour_i[5:0] == 6'h23);
        hour_o = c_day ? 8'h00 : bcd_inc({2'b00, hour_i[5:0]});
      end else if (hour_i[5:0] == 6'h12) begin
        // 12 to 1 keeps the afternoon flag as it is
        hour_o = {1'b1, hour_i[`HOUR_PM_BIT], 6'h01};
      end else if (hour_i[5:0] == 6'h11) begin
        // 11 to 12 flips morning and afternoon; PM 11 ends the day
        c_day  = hour_i[`HOUR_PM_BIT];
        hour_o = {1'b1, ~hour_i[`HOUR_PM_BIT], 6'h12};
      end else begin
        hour_o = bcd_inc({2'b00, hour_i[5:0]}) | {hour_i[7:6], 6'h00};
      end
    end
    // Leap year: counter at zero and leap handling not disabled
    leap_now = ~leap_wday_i[`LEAP_OFF_BIT] & (leap_wday_i[5:4] == 2'b00);
    case (month_i)
      8'h02:   last_day = leap_now ? 8'h29 : 8'h28;
      8'h04:   last_day = 8'h30;
      8'h06:   last_day = 8'h30;
      8'h09:   last_day = 8'h30;
      8'h11:   last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
    leap_wday_o = leap_wday_i;
    day_o       = day_i;
    c_mon       = 1'b0;
    if (c_day) begin
      leap_wday_o[3:0] = (leap_wday_i[3:0] >= 4'h6) ? 4'h0 : leap_wday_i[3:0] + 4'h1;
      c_mon = (day_i == last_day);
      day_o = c_mon ? 8'h01 : bcd_inc(day_i);
    end
    month_o = month_i;
    c_year  = 1'b0;
    if (c_mon) begin
      c_year  = (month_i == 8'h12);
      month_o = c_year ? 8'h01 : bcd_inc(month_i);
    end
    year_o = year_i;
    if (c_year) begin
      year_o = (year_i == 8'h99) ? 8'h00 : bcd_inc(year_i);
      leap_wday_o[5:4] = leap_wday_i[5:4] + 2'b01;
    end
  end

endmodule // calendar_advance

/* testbench/parallel_calendar_clock_regs_asserts.sv */
// Pin level checks for the calendar clock register block
`timescale 1ns/1ps
module parallel_calendar_clock_regs_asserts (
  // Clock and reset
  input wire       clk_i,
  input wire       rst_n_i,
  // Host bus pins
  input wire       select_low_active_n_i,
  input wire       select_high_active_i,
  input wire       write_strobe_n_i,
  input wire       read_strobe_n_i,
  input wire [2:0] register_select_lines_i,
  input wire [7:0] byte_bus_i,
  input wire [7:0] byte_bus_o,
  input wire       byte_bus_oe_o,
  // Timing pulse and crystal
  input wire       timing_pulse_out_o,
  input wire       timing_pulse_out_oe_o,
  input wire       crystal_in_i,
  input wire       crystal_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Pin filter takes about five cycles, eight leaves margin
  sequence rd_held;
    (!read_strobe_n_i && !select_low_active_n_i && select_high_active_i)[*8];
  endsequence
  sequence rd_idle;
    read_strobe_n_i[*8];
  endsequence
  chk_tp_low_only: assert property (timing_pulse_out_o == 1'b0)
    else $error("timing pulse pin driven high");
  chk_bus_idle_zero: assert property (!byte_bus_oe_o |-> byte_bus_o == 8'h00)
    else $error("read data present while bus released");
  chk_read_answer: assert property (rd_held |-> byte_bus_oe_o)
    else $error("selected read not answered");
  chk_idle_release: assert property (rd_idle |-> !byte_bus_oe_o)
    else $error("bus driven without read strobe");
  chk_low_deselect: assert property (select_low_active_n_i[*8] |-> !byte_bus_oe_o)
    else $error("bus driven while low select inactive");
  chk_high_deselect: assert property ((!select_high_active_i)[*8] |-> !byte_bus_oe_o)
    else $error("bus driven while high select inactive");
  chk_crystal_invert: assert property ($stable(crystal_in_i)[*8] |->
    crystal_out_o != crystal_in_i)
    else $error("crystal output not inverse of input");
  // Checked during reset itself, so the default disable is overridden
  chk_reset_idle: assert property (disable iff (1'b0)
    !rst_n_i |-> !byte_bus_oe_o && !timing_pulse_out_oe_o)
    else $error("pins not idle in reset");
endmodule // parallel_calendar_clock_regs_asserts

bind parallel_calendar_clock_regs parallel_calendar_clock_regs_asserts parallel_calendar_clock_regs_asserts_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .select_low_active_n_i(select_low_active_n_i),
  .select_high_active_i(select_high_active_i), .write_strobe_n_i(write_strobe_n_i),
  .read_strobe_n_i(read_strobe_n_i), .register_select_lines_i(register_select_lines_i),
  .byte_bus_i(byte_bus_i), .byte_bus_o(byte_bus_o), .byte_bus_oe_o(byte_bus_oe_o),
  .timing_pulse_out_o(timing_pulse_out_o), .timing_pulse_out_oe_o(timing_pulse_out_oe_o),
  .crystal_in_i(crystal_in_i), .crystal_out_o(crystal_out_o));

/* testbench/host_model.sv */
// Microprocessor model on the calendar clock byte bus
`timescale 1ns/1ps
module host_model (
  // Clock and resolved bus wire
  input  wire       clk_i,
  input  wire [7:0] byte_bus_i,
  // Pins driven by the host
  output reg        select_low_active_n_o,
  output reg        select_high_active_o,
  output reg        write_strobe_n_o,
  output reg        read_strobe_n_o,
  output reg  [2:0] register_select_lines_o,
  output reg  [7:0] byte_bus_o,
  output reg        byte_bus_oe_o
);
  // Idle bus at time zero
  initial begin
    select_low_active_n_o = 1'b1;
    select_high_active_o = 1'b0;
    write_strobe_n_o = 1'b1;
    read_strobe_n_o = 1'b1;
    register_select_lines_o = 3'h0;
    byte_bus_o = 8'h00;
    byte_bus_oe_o = 1'b0;
  end
  // Deselect and release; address scrambled so nothing relies on a stale one
  task idle;
    begin
      select_low_active_n_o = 1'b1;
      select_high_active_o = 1'b0;
      read_strobe_n_o = 1'b1;
      byte_bus_oe_o = 1'b0;
      register_select_lines_o = ~register_select_lines_o;
      repeat (4) @(negedge clk_i);
    end
  endtask
  // Write strobe lasts six cycles so the device's pin filter always sees it
  task wr(input [2:0] a, input [7:0] d, input [1:0] sel);
    begin
      @(negedge clk_i);
      {select_low_active_n_o, select_high_active_o} = sel;
      register_select_lines_o = a;
      byte_bus_o = d;
      byte_bus_oe_o = 1'b1;
      write_strobe_n_o = 1'b0;
      repeat (6) @(negedge clk_i);
      write_strobe_n_o = 1'b1;
      repeat (6) @(negedge clk_i);
      idle;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(negedge clk_i);
      {select_low_active_n_o, select_high_active_o} = 2'b01;
      register_select_lines_o = a;
      read_strobe_n_o = 1'b0;
      // Taken on a falling edge, clear of the edge that launches the read data
      repeat (8) @(negedge clk_i);
      d = byte_bus_i;
      @(negedge clk_i);
      idle;
    end
  endtask
endmodule // host_model

/* testbench/parallel_calendar_clock_regs_bench.sv */
// Self-checking bench for the calendar clock register block
`timescale 1ns/1ps
`include "calendar_clock_defs.vh"
module parallel_calendar_clock_regs_bench;
  reg         clk_i;
  reg         rst_n_i;
  reg         crystal_in_i;
  wire        csl_n, csh, wr_n, rd_n, host_oe, dev_oe, tp_oe, tp_out, crystal_out;
  wire [2:0]  addr;
  wire [7:0]  host_d, dev_d, bus_w;
  wire        tp_w;
  reg  [7:0]  bus_last;
  reg  [7:0]  v;
  reg  [7:0]  model_reg [0:6];
  reg  [31:0] hour_tab;
  reg  [27:0] tens_lim;
  integer     fails, checks_done, seed, i, j, r, t, u, hi, lo;
  // Undriven bus shows the inverse of its last level; no pull on it
  assign bus_w = dev_oe ? dev_d : (host_oe ? host_d : ~bus_last);
  assign tp_w = tp_oe ? tp_out : 1'b1; // Pull-up on the open drain pin
  always @(posedge clk_i) bus_last <= bus_w;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Crystal stand-in near 32.768 kHz, moved on falling edges like every other input
  initial begin
    crystal_in_i = 1'b0;
    forever begin
      repeat (305) @(negedge clk_i);
      crystal_in_i = ~crystal_in_i;
    end
  end
  parallel_calendar_clock_regs parallel_calendar_clock_regs_inst (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .select_low_active_n_i(csl_n), .select_high_active_i(csh),
    .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .register_select_lines_i(addr),
    .byte_bus_i(bus_w), .byte_bus_o(dev_d), .byte_bus_oe_o(dev_oe),
    .timing_pulse_out_o(tp_out), .timing_pulse_out_oe_o(tp_oe),
    .crystal_in_i(crystal_in_i), .crystal_out_o(crystal_out));
  host_model host_model_inst (.clk_i(clk_i), .byte_bus_i(bus_w),
    .select_low_active_n_o(csl_n), .select_high_active_o(csh), .write_strobe_n_o(wr_n),
    .read_strobe_n_o(rd_n), .register_select_lines_o(addr), .byte_bus_o(host_d),
    .byte_bus_oe_o(host_oe));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
    end
  endtask
  // Write through the host and update the model as the device should
  task mwrite(input [2:0] a, input [7:0] d);
    begin
      host_model_inst.wr(a, d, 2'b01);
      if (a == `ADDR_HOURS && !d[`HOUR_FMT_BIT])
        model_reg[a] = d & 8'hbf;
      else if (a == `ADDR_LEAP_WDAY && !d[`LEAP_WREN_BIT])
        model_reg[a] = {d[7:6], model_reg[a][5:4], d[3:0]};
      else
        model_reg[a] = d;
    end
  endtask
  task verify_all;
    begin
      for (r = 0; r < 7; r = r + 1) begin
        host_model_inst.rd(r[2:0], v);
        check(v, model_reg[r]);
      end
    end
  endtask
  task count_tp;
    begin
      hi = 0;
      lo = 0;
      repeat (12000) @(negedge clk_i) if (tp_w === 1'b0) hi = hi + 1; else lo = lo + 1;
    end
  endtask
  task results;
    begin
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Whole run is near 49000 cycles
  initial begin
    #4000000;
    fails = fails + 1;
    results;
  end
  initial begin
    fails = 0;
    checks_done = 0;
    seed = 82811;
    bus_last = 8'h5a;
    rst_n_i = 1'b0;
    hour_tab = {8'h13, 8'h92, 8'h45, 8'hc5};
    tens_lim = 28'ha130066;
    model_reg[0] = `RST_SECONDS;
    model_reg[1] = `RST_MINUTES;
    model_reg[2] = `RST_HOURS;
    model_reg[3] = `RST_LEAP_WDAY;
    model_reg[4] = `RST_DAY;
    model_reg[5] = `RST_MONTH;
    model_reg[6] = `RST_YEAR;
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    verify_all;
    host_model_inst.rd(`ADDR_MODE_CTRL, v);
    check(v & 8'h02, 8'h00);
    // Random valid BCD digits into the plain counters
    for (i = 0; i < 14; i = i + 1) begin
      j = i % 7;
      t = ($random(seed) & 32'hff) % tens_lim[4*j +: 4];
      u = ($random(seed) & 32'hff) % 9 + 1;
      if (j != 2 && j != 3) mwrite(j[2:0], {t[3:0], u[3:0]});
    end
    verify_all;
    for (i = 0; i < 4; i = i + 1) begin
      mwrite(`ADDR_HOURS, hour_tab[8*i +: 8]);
      host_model_inst.rd(`ADDR_HOURS, v);
      check(v, model_reg[2]);
    end
    mwrite(`ADDR_LEAP_WDAY, 8'h66);
    mwrite(`ADDR_LEAP_WDAY, 8'hb5);
    host_model_inst.rd(`ADDR_LEAP_WDAY, v);
    check(v, model_reg[3]);
    for (i = 0; i < 2; i = i + 1) begin
      host_model_inst.wr(`ADDR_SECONDS, 8'h30, (i == 0) ? 2'b11 : 2'b00);
      host_model_inst.rd(`ADDR_SECONDS, v);
      check(v, model_reg[0]);
    end
    // Adjust at 23:59:45 on 28 Feb with leap years off rolls to 1 Mar
    // Leap counter is set to 00, so only the control bits keep day 29 away
    mwrite(`ADDR_SECONDS, 8'h45);
    mwrite(`ADDR_MINUTES, 8'h59);
    mwrite(`ADDR_HOURS, 8'h23);
    mwrite(`ADDR_LEAP_WDAY, 8'hc5);
    mwrite(`ADDR_DAY, 8'h28);
    mwrite(`ADDR_MONTH, 8'h02);
    mwrite(`ADDR_YEAR, 8'h24);
    host_model_inst.wr(`ADDR_MODE_CTRL, 8'h04, 2'b01);
    model_reg[0] = 8'h00;
    model_reg[1] = 8'h00;
    model_reg[2] = 8'h00;
    model_reg[3] = model_reg[3] + 8'h01;
    model_reg[4] = 8'h01;
    model_reg[5] = 8'h03;
    verify_all;
    host_model_inst.wr(`ADDR_MODE_CTRL, 8'h02, 2'b01);
    host_model_inst.rd(`ADDR_MODE_CTRL, v);
    check(v & 8'hfa, 8'h02);
    count_tp;
    check({7'h00, hi > 0 && lo > 0}, 8'h01);
    host_model_inst.wr(`ADDR_MODE_CTRL, 8'h0c, 2'b01);
    count_tp;
    check({7'h00, hi == 0}, 8'h01);
    // Interval mode holds the pin low until stopped and reset
    host_model_inst.wr(`ADDR_MODE_CTRL, 8'h48, 2'b01);
    count_tp;
    check({7'h00, tp_w}, 8'h00);
    host_model_inst.wr(`ADDR_MODE_CTRL, 8'h49, 2'b01);
    host_model_inst.wr(`ADDR_MODE_CTRL, 8'h4b, 2'b01);
    count_tp;
    check({7'h00, hi == 0}, 8'h01);
    results;
  end
endmodule // parallel_calendar_clock_regs_bench
